/* File: design/dsm_drive1_status_mirror.sv */
module dsm_drive1_status_mirror
	import dsm_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [7:0] mcu_addr_in,
	input wire logic mcu_read_in,
	input wire logic mcu_write_in,
	input wire logic [7:0] mcu_wdata_in,
	input wire logic seek_done_drive1_in,
	input wire logic write_fault_drive1_in,
	input wire logic drive1_present_in,
	input wire logic reduced_current_drive1_in,
	input wire logic [7:0] host_drive_head_in,
	input wire logic [7:0] host_fixed_disk_in,
	output logic [7:0] mcu_rdata_out,
	output logic [3:0] host_drive_status_out,
	output logic host_drive_status_valid_out,
	output logic head_select3_enable_out
);
	import dsm_pkg::*;

	logic [STATUS_WIDTH-1:0] raw_status;
	logic [STATUS_WIDTH-1:0] sync_status;
	logic force_head3_enable_drive1_r;
	logic force_head3_enable_drive1_nxt;
	logic [7:0] mcu_rdata_r;
	logic [3:0] host_status_r;
	logic host_valid_r;
	logic head3_r;
	wire hit = (mcu_addr_in == DRIVE1_STATUS_CONTROL_ADDR);
	wire wr_hit = hit & mcu_write_in;
	wire rd_hit = hit & mcu_read_in;
	wire drive1_sel = host_drive_head_in[DRIVE_NUMBER_BIT];
	wire [7:0] reg_view;
	wire head3_next;

	assign raw_status = {reduced_current_drive1_in, drive1_present_in,
		write_fault_drive1_in, seek_done_drive1_in};

	dsm_sync u_sync (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.async_in(raw_status),
		.sync_out(sync_status)
	);

	// Status bits 0..3 come from the drive through the two-stage synchroniser, bit 4 is the stored override
	assign reg_view = {3'h0, force_head3_enable_drive1_r, sync_status};
	assign force_head3_enable_drive1_nxt = wr_hit ?
		mcu_wdata_in[FORCE_HEAD3_BIT] : force_head3_enable_drive1_r;
	assign head3_next = host_fixed_disk_in[HEAD3_ENABLE_BIT] |
		(drive1_sel & force_head3_enable_drive1_r);

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			force_head3_enable_drive1_r <= DRIVE1_STATUS_CONTROL_RESET[FORCE_HEAD3_BIT];
			mcu_rdata_r <= 8'h00;
			host_status_r <= 4'h0;
			host_valid_r <= 1'b0;
			head3_r <= 1'b0;
		end else begin
			force_head3_enable_drive1_r <= force_head3_enable_drive1_nxt;
			mcu_rdata_r <= rd_hit ? reg_view : 8'h00;
			host_status_r <= drive1_sel ? sync_status : 4'h0;
			host_valid_r <= drive1_sel;
			head3_r <= head3_next;
		end
	end

	assign mcu_rdata_out = mcu_rdata_r;
	assign host_drive_status_out = host_status_r;
	assign host_drive_status_valid_out = host_valid_r;
	assign head_select3_enable_out = head3_r;

	a_override_forces_head3: assert property (@(posedge clock_in) disable iff (reset_in)
		force_head3_enable_drive1_r && drive1_sel |=> head_select3_enable_out)
		else $error("override did not force head select 3 enable");
	a_write_stores_bit4: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_hit |=> force_head3_enable_drive1_r == $past(mcu_wdata_in[FORCE_HEAD3_BIT]))
		else $error("override bit not stored on write");
	a_nowrite_holds: assert property (@(posedge clock_in) disable iff (reset_in)
		!wr_hit |=> $stable(force_head3_enable_drive1_r))
		else $error("override bit changed without write");
	a_read_reserved_zero: assert property (@(posedge clock_in) disable iff (reset_in)
		mcu_rdata_out[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	a_status_sync_delay: assert property (@(posedge clock_in) disable iff (reset_in)
		rd_hit ##0 $past(raw_status, 2) == raw_status && $past(raw_status) == raw_status
		|=> mcu_rdata_out[3:0] == $past(raw_status))
		else $error("status bits not mirrored through synchroniser");
	a_host_view_drive1: assert property (@(posedge clock_in) disable iff (reset_in)
		drive1_sel |=> host_drive_status_valid_out && host_drive_status_out == $past(sync_status))
		else $error("host view missing drive 1 status");
	a_host_view_other: assert property (@(posedge clock_in) disable iff (reset_in)
		!drive1_sel |=> !host_drive_status_valid_out && host_drive_status_out == 4'h0)
		else $error("host view shown for other drive");
	a_reset_clears: assert property (@(posedge clock_in)
		reset_in |=> force_head3_enable_drive1_r == 1'b0 && mcu_rdata_out == 8'h00)
		else $error("reset did not clear register");
endmodule // dsm_drive1_status_mirror

/* File: design/dsm_pkg.sv */
package dsm_pkg;
	localparam logic [7:0] DRIVE1_STATUS_CONTROL_ADDR = 8'h57;
	localparam logic [7:0] DRIVE1_STATUS_CONTROL_RESET = 8'h00;
	localparam int SEEK_DONE_BIT = 0;
	localparam int WRITE_FAULT_BIT = 1;
	localparam int PRESENT_BIT = 2;
	localparam int REDUCED_CURRENT_BIT = 3;
	localparam int FORCE_HEAD3_BIT = 4;
	localparam int STATUS_WIDTH = 4;
	localparam int SYNC_STAGES = 2;
	localparam int DRIVE_NUMBER_BIT = 4;
	localparam int HEAD3_ENABLE_BIT = 3;
	localparam logic [7:0] WRITE_MASK = 8'h10;
endpackage

/* File: design/dsm_sync.sv */
module dsm_sync
	import dsm_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [STATUS_WIDTH-1:0] async_in,
	output logic [STATUS_WIDTH-1:0] sync_out
);
	logic [STATUS_WIDTH-1:0] stage1_r;
	logic [STATUS_WIDTH-1:0] stage2_r;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
		end
	end

	assign sync_out = stage2_r;
endmodule // dsm_sync

/* File: tb/dsm_drive_model.sv */
module dsm_drive_model (
	input wire logic [3:0] state_in,
	output logic seek_done_drive1_out,
	output logic write_fault_drive1_out,
	output logic drive1_present_out,
	output logic reduced_current_drive1_out
);
	timeunit 1ns;
	timeprecision 1ns;
	assign {reduced_current_drive1_out, drive1_present_out,
		write_fault_drive1_out, seek_done_drive1_out} = state_in;
endmodule // dsm_drive_model

/* File: tb/tb_drive1_status_mirror.sv */
module tb_drive1_status_mirror;
	import dsm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, rd_s = 0, wr_s = 0, sd, wf, dp, rc, hs3, hv, ovr;
	logic [7:0] adr = 0, wd = 0, dh = 0, fd = 0, rdat;
	logic [3:0] st = 0, hst;
	int fail_count = 0, total_checks = 0, seed;
	initial forever #12.5 clk = ~clk;
	dsm_drive_model drv (.state_in(st), .seek_done_drive1_out(sd),
		.write_fault_drive1_out(wf), .drive1_present_out(dp),
		.reduced_current_drive1_out(rc));
	dsm_drive1_status_mirror DUT (.clock_in(clk), .reset_in(rst),
		.mcu_addr_in(adr), .mcu_read_in(rd_s), .mcu_write_in(wr_s),
		.mcu_wdata_in(wd), .seek_done_drive1_in(sd),
		.write_fault_drive1_in(wf), .drive1_present_in(dp),
		.reduced_current_drive1_in(rc), .host_drive_head_in(dh),
		.host_fixed_disk_in(fd), .mcu_rdata_out(rdat),
		.host_drive_status_out(hst), .host_drive_status_valid_out(hv),
		.head_select3_enable_out(hs3));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		adr = a;
		rd_s = 1;
		cyc(1);
		rd_s = 0;
		chk(rdat, exp);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		seed = $urandom(90);
		cyc(20);
		rst = 0;
		rd(8'h57, 8'h00);
		for (int i = 0; i < 12; i++) begin
			st = 4'($urandom);
			wd = 8'($urandom);
			ovr = wd[4];
			adr = 8'h57;
			wr_s = 1;
			cyc(1);
			wr_s = 0;
			cyc(3);
			rd(8'h57, {3'h0, ovr, st});
			// Host drive/head and fixed-disk values are randomised on every pass
			dh = 8'($urandom);
			fd = 8'($urandom);
			cyc(2);
			chk({3'h0, hv, hst}, {3'h0, dh[4], dh[4] ? st : 4'h0});
			chk({7'h0, hs3}, {7'h0, fd[3] | (dh[4] & ovr)});
			$display("pass %0d done", i);
		end
		rd(8'h56, 8'h00);
		rst = 1;
		cyc(2);
		rst = 0;
		cyc(3);
		rd(8'h57, {4'h0, st});
		$display("reset test done");
		test_done;
	end
	initial begin
		#20000;
		fail_count++;
		test_done;
	end
endmodule // tb_drive1_status_mirror
